//--- design/bds_ctl.sv
// Controller end: makes the link clocks, issues bursts and gathers read beats
`timescale 1ns/1ps
`default_nettype none
module bds_ctl #(
	parameter int DATA_W     = bds_pkg::DATA_W,
	parameter int ADDR_W     = bds_pkg::ADDR_W,
	parameter int K_HALF     = bds_pkg::K_HALF_CYC,
	parameter bit SINGLE_CLK = 1'b0
) (
	// System
	input  wire logic                                        CLOCK,
	input  wire logic                                        SRST,
	input  wire logic                                        CE,
	// Configuration
	input  wire logic                                        DLL_EN,
	// Read request
	input  wire logic                                        RD_VALID,
	input  wire logic [ADDR_W-1:0]                           RD_ADDR,
	output var  logic                                        RD_TAKEN,
	// Write request
	input  wire logic                                        WR_VALID,
	input  wire logic [ADDR_W-1:0]                           WR_ADDR,
	input  wire logic [bds_pkg::BURST*DATA_W-1:0]            WR_DATA,
	input  wire logic [bds_pkg::BURST*DATA_W/bds_pkg::LANE_W-1:0] WR_BYTE_N,
	output var  logic                                        WR_TAKEN,
	// Read answer
	output var  logic                                        RSP_VALID,
	output var  logic [DATA_W-1:0]                           RSP_DATA,
	output var  logic [1:0]                                  RSP_BEAT,
	// Link pins
	bds_link_if.ctl                                          LINK
);
	localparam int LANES = DATA_W / bds_pkg::LANE_W;
	localparam int BW    = bds_pkg::BURST * LANES;
	localparam int HW    = $clog2(K_HALF + 1);

	if (K_HALF < bds_pkg::K_HALF_MIN || !(DATA_W == 36 || DATA_W == 18)) begin : g_bad_cfg
		$error("bds_ctl: link half period too short or bad width");
	end

	logic [HW-1:0]                     hc_q;
	logic                              k_q, kn_q, c_q, cn_q;
	logic                              rise_ev, fall_ev, half_ev;
	logic                              rd_last_q, wr_last_q, rd_go, wr_go;
	logic                              rd_n_q, wr_n_q, doff_n_q;
	logic [ADDR_W-1:0]                 a_q;
	bds_pkg::bds_wph_e                 wph_q;
	logic [bds_pkg::BURST*DATA_W-1:0]  cur_d_q, nxt_d_q;
	logic [BW-1:0]                     cur_b_q, nxt_b_q;
	logic                              nxt_v_q;
	logic [1:0]                        wbeat;
	logic [DATA_W-1:0]                 d_q;
	logic [LANES-1:0]                  bw_q;
	logic                              rtk_q, wtk_q;
	logic [2:0]                        e_q;
	logic [DATA_W-1:0]                 q1_q, q2_q;
	logic                              e_edge;
	logic [6:0]                        sched_q, sched;
	logic [1:0]                        rb_q;
	logic                              rv_q;
	logic [DATA_W-1:0]                 rd_q;
	logic [1:0]                        rbo_q;

	// Link clock divider; events fire on the cycle before the level changes
	assign half_ev = CE & (hc_q == HW'(K_HALF - 1));
	assign rise_ev = half_ev & ~k_q;
	assign fall_ev = half_ev & k_q;
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			hc_q <= '0;
			k_q  <= 1'b0;
			kn_q <= 1'b1;
			c_q  <= SINGLE_CLK;
			cn_q <= 1'b1;
		end else if (CE) begin
			hc_q <= half_ev ? '0 : hc_q + HW'(1);
			if (half_ev) begin
				k_q  <= ~k_q;
				kn_q <= k_q;
				c_q  <= SINGLE_CLK ? 1'b1 : ~k_q;
				cn_q <= SINGLE_CLK ? 1'b1 : k_q;
			end
		end
	end

	// Command set up half a cycle before the true-clock rise, one per rise
	assign rd_go = RD_VALID & ~rd_last_q;
	assign wr_go = WR_VALID & ~wr_last_q & ~rd_go;
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			rd_last_q <= 1'b0;
			wr_last_q <= 1'b0;
			rd_n_q    <= 1'b1;
			wr_n_q    <= 1'b1;
			a_q       <= '0;
			rtk_q     <= 1'b0;
			wtk_q     <= 1'b0;
			doff_n_q  <= 1'b0;
		end else if (CE) begin
			rtk_q    <= fall_ev & rd_go;
			wtk_q    <= fall_ev & wr_go;
			doff_n_q <= DLL_EN;
			if (fall_ev) begin
				rd_last_q <= rd_go;
				wr_last_q <= wr_go;
				rd_n_q    <= ~rd_go;
				wr_n_q    <= ~wr_go;
				a_q       <= rd_go ? RD_ADDR : WR_ADDR;
			end
		end
	end

	// Write beats driven half a cycle ahead of the edge that captures them
	assign wbeat = 2'(wph_q - bds_pkg::WPH_B0);
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			wph_q   <= bds_pkg::WPH_IDLE;
			nxt_v_q <= 1'b0;
			d_q     <= '0;
			bw_q    <= '1;
		end else if (half_ev) begin
			case (wph_q)
				bds_pkg::WPH_IDLE: begin
					bw_q <= '1;
				end
				bds_pkg::WPH_ARMED: wph_q <= bds_pkg::WPH_B0;
				bds_pkg::WPH_B0, bds_pkg::WPH_B1, bds_pkg::WPH_B2, bds_pkg::WPH_B3: begin
					d_q  <= cur_d_q[wbeat*DATA_W +: DATA_W];
					bw_q <= cur_b_q[wbeat*LANES +: LANES];
					if (wph_q == bds_pkg::WPH_B3) begin
						wph_q   <= nxt_v_q ? bds_pkg::WPH_B0 : bds_pkg::WPH_IDLE;
						cur_d_q <= nxt_d_q;
						cur_b_q <= nxt_b_q;
						nxt_v_q <= 1'b0;
					end else begin
						wph_q <= bds_pkg::bds_wph_e'(wph_q + 3'h1);
					end
				end
				default: wph_q <= bds_pkg::WPH_IDLE;
			endcase
			if (fall_ev && wr_go) begin
				if (wph_q == bds_pkg::WPH_IDLE) begin
					wph_q   <= bds_pkg::WPH_ARMED;
					cur_d_q <= WR_DATA;
					cur_b_q <= WR_BYTE_N;
				end else begin
					nxt_v_q <= 1'b1;
					nxt_d_q <= WR_DATA;
					nxt_b_q <= WR_BYTE_N;
				end
			end
		end
	end

	// Echo clock and read data pass two flip-flops
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			e_q  <= 3'h0;
			q1_q <= '0;
			q2_q <= '0;
		end else if (CE) begin
			e_q  <= {e_q[1:0], LINK.echo_clock};
			q1_q <= LINK.read_data_bus;
			q2_q <= q1_q;
		end
	end
	assign e_edge = e_q[2] ^ e_q[1];

	// Read beats taken on echo edges 4 to 7 from the request edge
	assign sched = sched_q | ((rise_ev & ~rd_n_q) ? bds_pkg::RD_SCHED : 7'h00);
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			sched_q <= 7'h00;
			rb_q    <= 2'h0;
			rv_q    <= 1'b0;
			rd_q    <= '0;
			rbo_q   <= 2'h0;
		end else if (CE) begin
			rv_q    <= 1'b0;
			sched_q <= e_edge ? {1'b0, sched[6:1]} : sched;
			if (e_edge && sched[0]) begin
				rv_q  <= 1'b1;
				rd_q  <= q2_q;
				rbo_q <= rb_q;
				rb_q  <= rb_q + 2'h1;
			end
		end
	end

	assign LINK.k             = k_q;
	assign LINK.k_n           = kn_q;
	assign LINK.c             = c_q;
	assign LINK.c_n           = cn_q;
	assign LINK.rd_n          = rd_n_q;
	assign LINK.wr_n          = wr_n_q;
	assign LINK.dll_off_n     = doff_n_q;
	assign LINK.addr_in       = a_q;
	assign LINK.write_data_in = d_q;
	assign LINK.byte_write_n  = bw_q;
	assign RD_TAKEN           = rtk_q;
	assign WR_TAKEN           = wtk_q;
	assign RSP_VALID          = rv_q;
	assign RSP_DATA           = rd_q;
	assign RSP_BEAT           = rbo_q;
endmodule // bds_ctl
`default_nettype wire

//--- design/bds_dev.sv
// Memory end: burst-of-four DDR static memory with separate read and write ports
`timescale 1ns/1ps
`default_nettype none
// Function
// - Every access is a four-word burst
// - Read and write ports run concurrently
// - Commands sampled on input clock rise only
// - Write beats one and three on true clock, read beats two and four
// - Write beats two and four on complementary clock, read beats one and three
// - Byte strobes apply per lane per beat
// - First write beat one cycle after request
// - Write burst takes two cycles, no back-to-back
// - Read starts on low read request, alternate cycles
// - Output clocks time beats from 1.5 cycles
// - Output clocks tied high: input clocks time beats
// - Free-running echo clock pair matches data
// - Idle request does not cut a burst
// - Low disable input switches loop off
// - Write request is active low
// - Byte strobes guard nine-bit lanes
// - Last two writes buffered, reads of the same base address see them
// - Burst address steps base to base+3
// - Repeat request on next edge is ignored
// - Read and write together: write ignored
module bds_dev #(
	parameter int DATA_W = bds_pkg::DATA_W,
	parameter int ADDR_W = bds_pkg::ADDR_W
) (
	// System
	input  wire logic   CLOCK,
	input  wire logic   SRST,
	input  wire logic   CE,
	// Status
	output var  logic   DLL_ACTIVE,
	// Link pins
	bds_link_if.dev     LINK
);
	localparam int BURST = bds_pkg::BURST;
	localparam int LANES = DATA_W / bds_pkg::LANE_W;
	localparam int WORDS = 1 << ADDR_W;
	localparam int SW    = 7 + ADDR_W + DATA_W + LANES;

	// Only the two documented organisations are served
	if (!((DATA_W == 36 && ADDR_W <= bds_pkg::ADDR_W) || (DATA_W == 18 && ADDR_W <= bds_pkg::ADDR_W_MAX))
		|| ADDR_W < 2) begin : g_bad_size
		$error("bds_dev: unsupported data or address width");
	end

	typedef logic [DATA_W-1:0] bds_word_t;

	// Overlay the enabled lanes of a new word onto an old one
	function automatic bds_word_t lane_merge(bds_word_t old_w, bds_word_t new_w, logic [LANES-1:0] en);
		bds_word_t r;
		r = old_w;
		for (int l = 0; l < LANES; l++) begin
			if (en[l]) begin
				r[l*bds_pkg::LANE_W +: bds_pkg::LANE_W] = new_w[l*bds_pkg::LANE_W +: bds_pkg::LANE_W];
			end
		end
		return r;
	endfunction

	// Linear burst stepping, wraps at the top of the array
	function automatic logic [ADDR_W-1:0] beat_addr(logic [ADDR_W-1:0] base, int i);
		return base + ADDR_W'(i);
	endfunction

	logic [SW-1:0]       s1_q;
	logic [SW-1:0]       s2_q;
	logic                k_s, kn_s, c_s, cn_s, rd_n_s, wr_n_s, doff_n_s;
	logic [ADDR_W-1:0]   addr_s;
	logic [DATA_W-1:0]   wd_s;
	logic [LANES-1:0]    bw_n_s;
	logic [DATA_W+LANES-1:0] wp_q;
	logic [3:0]          clk3_q;
	logic                k_rise, kn_rise, c_rise, cn_rise;
	logic                tied_q;
	logic                out_edge, in_edge;
	logic                rd_last_q, wr_last_q;
	logic                rd_ok, wr_ok;
	bds_word_t           mem [WORDS];
	bds_word_t           rd_img [BURST];
	logic                wb_v_q [2];
	logic [ADDR_W-1:0]   wb_a_q [2];
	bds_word_t           wb_d_q [2][BURST];
	logic [LANES-1:0]    wb_be_q [2][BURST];
	bds_pkg::bds_wph_e   wph_q;
	logic [1:0]          wbeat;
	logic                done_q;
	logic [ADDR_W-1:0]   as_a_q;
	bds_word_t           as_d_q [BURST];
	logic [LANES-1:0]    as_be_q [BURST];
	logic                wn_v_q;
	logic [ADDR_W-1:0]   wn_a_q;
	bds_word_t           f_d_q [2][BURST];
	logic                f_wp_q, f_rp_q;
	logic [1:0]          f_cnt_q;
	logic                f_in_ready, f_push, f_out_valid, f_pop;
	logic [6:0]          sched_q;
	logic [6:0]          sched;
	logic [1:0]          beat_q;
	logic [DATA_W-1:0]   q_q;
	logic                oe_q, cq_q, cqn_q, dll_q;

	// Every pin passes two flip-flops; reset loads all ones, the idle level of the active-low pins
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			s1_q <= '1;
			s2_q <= '1;
		end else if (CE) begin
			s1_q <= {LINK.k, LINK.k_n, LINK.c, LINK.c_n, LINK.rd_n, LINK.wr_n, LINK.dll_off_n,
				LINK.addr_in, LINK.write_data_in, LINK.byte_write_n};
			s2_q <= s1_q;
		end
	end
	assign {k_s, kn_s, c_s, cn_s, rd_n_s, wr_n_s, doff_n_s, addr_s, wd_s, bw_n_s} = s2_q;

	// Edge finder on the synchronised clock levels
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			clk3_q <= 4'hf;
			tied_q <= 1'b0;
		end else if (CE) begin
			clk3_q <= {k_s, kn_s, c_s, cn_s};
			wp_q   <= {wd_s, bw_n_s}; // Level before the edge: the far end moves data with its clock
			tied_q <= c_s & cn_s;
		end
	end
	assign k_rise   = k_s & ~clk3_q[3];
	assign kn_rise  = kn_s & ~clk3_q[2];
	assign c_rise   = c_s & ~clk3_q[1];
	assign cn_rise  = cn_s & ~clk3_q[0];
	assign in_edge  = k_rise | kn_rise;
	// Output pair, or the input pair when the output pair is tied high
	assign out_edge = tied_q ? (k_rise | kn_rise) : (c_rise | cn_rise);

	// Command decode, one address per rising edge; read wins a tie
	assign rd_ok = k_rise & ~rd_n_s & ~rd_last_q & f_in_ready;
	assign wr_ok = k_rise & ~wr_n_s & ~wr_last_q & ~rd_ok;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			rd_last_q <= 1'b0;
			wr_last_q <= 1'b0;
		end else if (CE && k_rise) begin
			rd_last_q <= rd_ok;
			wr_last_q <= wr_ok;
		end
	end

	// Burst image for a read, newest buffered write taking precedence
	always_comb begin
		for (int i = 0; i < BURST; i++) begin
			rd_img[i] = mem[beat_addr(addr_s, i)];
			for (int b = 1; b >= 0; b--) begin
				if (wb_v_q[b] && wb_a_q[b] == addr_s) begin
					rd_img[i] = lane_merge(rd_img[i], wb_d_q[b][i], wb_be_q[b][i]);
				end
			end
		end
	end

	// Write beat capture on both input clock rises
	assign wbeat = 2'(wph_q - bds_pkg::WPH_B0);
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			wph_q  <= bds_pkg::WPH_IDLE;
			done_q <= 1'b0;
			wn_v_q <= 1'b0;
			as_a_q <= '0;
			wn_a_q <= '0;
		end else if (CE) begin
			done_q <= 1'b0;
			if (in_edge) begin
				case (wph_q)
					bds_pkg::WPH_IDLE:  wph_q <= bds_pkg::WPH_IDLE;
					bds_pkg::WPH_ARMED: wph_q <= bds_pkg::WPH_B0;
					bds_pkg::WPH_B0, bds_pkg::WPH_B1, bds_pkg::WPH_B2: begin
						as_d_q[wbeat]  <= wp_q[LANES +: DATA_W];
						as_be_q[wbeat] <= ~wp_q[LANES-1:0];
						wph_q          <= bds_bump(wph_q);
					end
					bds_pkg::WPH_B3: begin
						as_d_q[wbeat]  <= wp_q[LANES +: DATA_W];
						as_be_q[wbeat] <= ~wp_q[LANES-1:0];
						done_q         <= 1'b1;
						wph_q          <= wn_v_q ? bds_pkg::WPH_B0 : bds_pkg::WPH_IDLE;
					end
					default: wph_q <= bds_pkg::WPH_IDLE;
				endcase
			end
			// Address follows the burst once the previous one has been handed on
			if (done_q && wn_v_q) begin
				as_a_q <= wn_a_q;
				wn_v_q <= 1'b0;
			end
			if (wr_ok) begin
				if (wph_q == bds_pkg::WPH_IDLE) begin
					wph_q  <= bds_pkg::WPH_ARMED;
					as_a_q <= addr_s;
				end else begin
					wn_v_q <= 1'b1;
					wn_a_q <= addr_s;
				end
			end
		end
	end

	function automatic bds_pkg::bds_wph_e bds_bump(bds_pkg::bds_wph_e p);
		return bds_pkg::bds_wph_e'(p + 3'h1);
	endfunction

	// Two-deep write buffer; the older entry reaches the array on the next completed burst
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			wb_v_q[0] <= 1'b0;
			wb_v_q[1] <= 1'b0;
		end else if (CE && done_q) begin
			wb_v_q[1]  <= wb_v_q[0];
			wb_a_q[1]  <= wb_a_q[0];
			wb_d_q[1]  <= wb_d_q[0];
			wb_be_q[1] <= wb_be_q[0];
			wb_v_q[0]  <= 1'b1;
			wb_a_q[0]  <= as_a_q;
			wb_d_q[0]  <= as_d_q;
			wb_be_q[0] <= as_be_q;
		end
	end

	// Array update, separate from reads so both ports work at once
	always_ff @(posedge CLOCK) begin
		if (CE && !SRST && done_q && wb_v_q[1]) begin
			for (int i = 0; i < BURST; i++) begin
				mem[beat_addr(wb_a_q[1], i)] <= lane_merge(mem[beat_addr(wb_a_q[1], i)],
					wb_d_q[1][i], wb_be_q[1][i]);
			end
		end
	end

	// Two-entry burst buffer between array read and output pins
	assign f_in_ready  = (f_cnt_q != 2'h2);
	assign f_push      = rd_ok;
	assign f_out_valid = (f_cnt_q != 2'h0);
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			f_wp_q  <= 1'b0;
			f_rp_q  <= 1'b0;
			f_cnt_q <= 2'h0;
		end else if (CE) begin
			if (f_push) begin
				f_d_q[f_wp_q] <= rd_img;
				f_wp_q        <= ~f_wp_q;
			end
			if (f_pop) begin
				f_rp_q <= ~f_rp_q;
			end
			f_cnt_q <= f_cnt_q + {1'b0, f_push} - {1'b0, f_pop};
		end
	end

	// Beat schedule over output-clock edges; bursts never overlap at legal spacing
	assign sched = sched_q | (f_push ? bds_pkg::RD_SCHED : 7'h00);
	assign f_pop = CE & out_edge & sched[0] & f_out_valid & (beat_q == bds_pkg::LAST_BEAT);
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			sched_q <= 7'h00;
			beat_q  <= 2'h0;
			q_q     <= '0;
			oe_q    <= 1'b0;
		end else if (CE) begin
			sched_q <= out_edge ? {1'b0, sched[6:1]} : sched;
			if (out_edge) begin
				if (sched[0] && f_out_valid) begin
					q_q    <= f_d_q[f_rp_q][beat_q];
					oe_q   <= 1'b1;
					beat_q <= beat_q + 2'h1;
				end else begin
					oe_q <= 1'b0;
				end
			end
		end
	end

	// Echo pair follows the clock that times the data
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			cq_q  <= 1'b0;
			cqn_q <= 1'b1;
			dll_q <= 1'b0;
		end else if (CE) begin
			cq_q  <= tied_q ? k_s : c_s;
			cqn_q <= tied_q ? ~k_s : ~c_s;
			dll_q <= doff_n_s;
		end
	end

	assign LINK.read_data_out = q_q;
	assign LINK.read_data_oe  = oe_q;
	assign LINK.echo_clock    = cq_q;
	assign LINK.echo_clock_n  = cqn_q;
	assign DLL_ACTIVE         = dll_q;
endmodule // bds_dev
`default_nettype wire

//--- design/bds_link_if.sv
// Pin bundle between the burst memory and its controller
`timescale 1ns/1ps
`default_nettype none
interface bds_link_if #(
	parameter int DATA_W = bds_pkg::DATA_W,
	parameter int ADDR_W = bds_pkg::ADDR_W
);
	localparam int LANES = DATA_W / bds_pkg::LANE_W;

	logic              k;
	logic              k_n;
	logic              c;
	logic              c_n;
	logic              rd_n;
	logic              wr_n;
	logic              dll_off_n;
	logic [ADDR_W-1:0] addr_in;
	logic [DATA_W-1:0] write_data_in;
	logic [LANES-1:0]  byte_write_n;
	logic [DATA_W-1:0] read_data_out;
	logic              read_data_oe;
	logic              echo_clock;
	logic              echo_clock_n;
	logic [DATA_W-1:0] read_data_bus;

	// Released wires show the inverse, so a sample outside a beat stands out
	assign read_data_bus = read_data_oe ? read_data_out : ~read_data_out;

	modport dev (
		input  k, k_n, c, c_n, rd_n, wr_n, dll_off_n, addr_in, write_data_in, byte_write_n,
		output read_data_out, read_data_oe, echo_clock, echo_clock_n
	);
	modport ctl (
		output k, k_n, c, c_n, rd_n, wr_n, dll_off_n, addr_in, write_data_in, byte_write_n,
		input  read_data_bus, echo_clock
	);
endinterface
`default_nettype wire

//--- design/bds_pkg.sv
// Shared constants and types for the burst-of-four DDR static memory link
package bds_pkg;
	localparam int BURST      = 4;             // Words in every read or write burst
	localparam int LANE_W     = 9;             // Bits guarded by one byte-write strobe
	localparam int DATA_W     = 36;            // Word width of the wide variant
	localparam int ADDR_W     = 20;            // Address bits of the wide variant
	localparam int ADDR_W_MAX = 21;            // Narrow variant carries one more bit
	localparam int CLK_NS     = 4;             // System clock period
	localparam int K_HALF_NS  = 80;            // Half period of the link clock made by the controller
	localparam int K_HALF_CYC = K_HALF_NS / CLK_NS;
	localparam int K_HALF_MIN = 8;             // Must exceed the echo round trip through both synchronisers
	// Read beats land on the 4th to 7th output-clock edge, the request edge counted as the 1st
	localparam logic [6:0] RD_SCHED = 7'h78;
	localparam logic [1:0] LAST_BEAT = 2'h3;

	// Write beat phase, shared by the capturing and the driving end
	typedef enum logic [2:0] {
		WPH_IDLE  = 3'h0,
		WPH_ARMED = 3'h1,
		WPH_B0    = 3'h2,
		WPH_B1    = 3'h3,
		WPH_B2    = 3'h4,
		WPH_B3    = 3'h5
	} bds_wph_e;
endpackage

//--- testbench/bds_link_assertions.sv
// Protocol checks on the pins between the controller and the burst memory
`timescale 1ns/1ps
`default_nettype none
module bds_link_assertions #(
	parameter int ADDR_W = 6,
	parameter int KH     = 8
) (
	// System
	input wire logic              CLOCK,
	input wire logic              SRST,
	// Controller driven pins
	input wire logic              k,
	input wire logic              k_n,
	input wire logic              c,
	input wire logic              c_n,
	input wire logic              rd_n,
	input wire logic              wr_n,
	input wire logic [ADDR_W-1:0] addr_in,
	// Memory driven pins
	input wire logic              read_data_oe,
	input wire logic              echo_clock,
	input wire logic              echo_clock_n
);
	localparam int LAT_LO = 4 * KH - 2;
	localparam int LAT_HI = 4 * KH + 6;
	logic [7:0] k_hi_q;
	logic [7:0] rd_hi_q;
	logic [7:0] wr_hi_q;
	logic [9:0] oe_q;

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SRST);

	// Run lengths; request gaps saturate so a long idle never wraps to a false short gap
	always_ff @(posedge CLOCK) k_hi_q <= (SRST || !k) ? 8'h00 : k_hi_q + 8'h01;
	always_ff @(posedge CLOCK) rd_hi_q <= SRST ? 8'hff : (!rd_n ? 8'h00 : (rd_hi_q == 8'hff ? 8'hff : rd_hi_q + 8'h01));
	always_ff @(posedge CLOCK) wr_hi_q <= SRST ? 8'hff : (!wr_n ? 8'h00 : (wr_hi_q == 8'hff ? 8'hff : wr_hi_q + 8'h01));
	always_ff @(posedge CLOCK) oe_q <= (SRST || !read_data_oe) ? 10'h000 : oe_q + 10'h001;

	// A taken read shows its first beat two link cycles after rd_n falls, plus sync lag
	sequence s_rd_req;
		$fell(rd_n);
	endsequence
	sequence s_first_beat;
		##[LAT_LO:LAT_HI] read_data_oe;
	endsequence

	AST_ECHO_PAIR: assert property (echo_clock_n == !echo_clock)
		else $error("echo clocks not complementary");
	AST_K_PAIR: assert property (k_n == !k)
		else $error("input clocks not complementary");
	AST_C_PAIR: assert property (c_n == !c)
		else $error("output timing clocks not complementary");
	AST_K_HALF: assert property ($fell(k) |-> k_hi_q == 8'(KH))
		else $error("input clock high phase has wrong length");
	AST_RD_GAP: assert property ($fell(rd_n) |-> rd_hi_q >= 8'(2 * KH))
		else $error("read requests on consecutive input clock rises");
	AST_WR_GAP: assert property ($fell(wr_n) |-> wr_hi_q >= 8'(2 * KH))
		else $error("write requests on consecutive input clock rises");
	AST_OE_RUN: assert property ($fell(read_data_oe) |-> (oe_q % (4 * KH)) == 0)
		else $error("read data driven for a partial burst");
	AST_RD_LAT: assert property (s_rd_req |-> s_first_beat)
		else $error("read data did not appear on time");
	AST_ADDR_HOLD: assert property (((!rd_n && $past(!rd_n)) || (!wr_n && $past(!wr_n))) |-> $stable(addr_in))
		else $error("address moved during a request");
endmodule // bds_link_assertions
`default_nettype wire

//--- testbench/burst4_ddr_sram_interface_bench.sv
// Bench joining the controller and memory ends of the burst link
`timescale 1ns/1ps
`default_nettype none
module burst4_ddr_sram_interface_bench;
	localparam int DW = bds_pkg::DATA_W;
	localparam int AW = 6;
	localparam int KH = bds_pkg::K_HALF_MIN;   // Short link period keeps the run brief
	localparam int TMO = 40 * KH;

	logic            clock = 1'b0;
	logic            srst = 1'b1;
	logic            dll_en = 1'b1;
	logic            rd_valid = 1'b0;
	logic            wr_valid = 1'b0;
	logic [AW-1:0]   rd_addr = 6'h00;
	logic [AW-1:0]   wr_addr = 6'h00;
	logic [4*DW-1:0] wr_data = {(4*DW){1'b0}};
	logic [15:0]     wr_byte_n = 16'hffff;
	logic            rd_taken, wr_taken, rsp_valid, dll_active;
	logic [DW-1:0]   rsp_data;
	logic [1:0]      rsp_beat;
	logic [DW-1:0]   mem [64];
	logic [DW+1:0]   exp_q [$];
	logic [31:0]     seed = 32'hd03f;
	int              fails = 0;
	int              checks_done = 0;

	bds_link_if #(.DATA_W(DW), .ADDR_W(AW)) link ();
	bds_ctl #(.DATA_W(DW), .ADDR_W(AW), .K_HALF(KH)) bds_ctl_i (.CLOCK(clock), .SRST(srst), .CE(1'b1),
		.DLL_EN(dll_en), .RD_VALID(rd_valid), .RD_ADDR(rd_addr), .RD_TAKEN(rd_taken), .WR_VALID(wr_valid),
		.WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_BYTE_N(wr_byte_n), .WR_TAKEN(wr_taken),
		.RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_BEAT(rsp_beat), .LINK(link.ctl));
	bds_dev #(.DATA_W(DW), .ADDR_W(AW)) bds_dev_i (.CLOCK(clock), .SRST(srst), .CE(1'b1),
		.DLL_ACTIVE(dll_active), .LINK(link.dev));
	bds_link_assertions #(.ADDR_W(AW), .KH(KH)) bds_link_assertions_i (.CLOCK(clock), .SRST(srst),
		.k(link.k), .k_n(link.k_n), .c(link.c), .c_n(link.c_n), .rd_n(link.rd_n), .wr_n(link.wr_n),
		.addr_in(link.addr_in), .read_data_oe(link.read_data_oe), .echo_clock(link.echo_clock),
		.echo_clock_n(link.echo_clock_n));

	// System clock, 4 ns
	initial forever #2 clock = ~clock;

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Lane-wise merge; a high strobe keeps the old lane
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw, input logic [3:0] bn);
		logic [DW-1:0] r;
		r = old;
		for (int l = 0; l < 4; l++) if (!bn[l]) r[l*9 +: 9] = nw[l*9 +: 9];
		return r;
	endfunction

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic cmp_word(input logic [DW+1:0] got, input logic [DW+1:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t read beat %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	// Bounded wait for the user port to accept; a hang ends the run
	task automatic wait_taken(input bit wr);
		int n;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while ((wr ? wr_taken : rd_taken) !== 1'b1 && n < TMO);
		if (n >= TMO) begin
			fails++;
			$display("ERROR %0t request never taken", $time);
			end_sim();
		end
	endtask

	task automatic do_write(input logic [AW-1:0] a, input logic [15:0] bn);
		logic [DW-1:0] w;
		@(negedge clock);
		for (int i = 0; i < 4; i++) begin
			w = DW'({xs(), xs()});
			wr_data[i*DW +: DW] = w;
			mem[a + 6'(i)] = merge(mem[a + 6'(i)], w, bn[i*4 +: 4]);
		end
		wr_valid = 1'b1;
		wr_addr = a;
		wr_byte_n = bn;
		wait_taken(1'b1);
		wr_valid = 1'b0;
	endtask

	task automatic do_read(input logic [AW-1:0] a);
		@(negedge clock);
		for (int i = 0; i < 4; i++) exp_q.push_back({2'(i), mem[a + 6'(i)]});
		rd_valid = 1'b1;
		rd_addr = a;
		wait_taken(1'b0);
		rd_valid = 1'b0;
	endtask

	// Each beat must be the next expected word; a surplus beat meets an unknown and fails
	always @(negedge clock) begin
		if (rsp_valid === 1'b1) begin
			cmp_word({rsp_beat, rsp_data}, exp_q.size() != 0 ? exp_q.pop_front() : {(DW+2){1'bx}});
		end
	end

	initial begin
		repeat (2) @(negedge clock);
		srst = 1'b0;
		// Full bursts lay down a known image, then per-beat strobe patterns
		for (int b = 0; b < 8; b++) do_write(6'(b * 4), 16'h0000); // All lanes
		do_write(6'h00, 16'h7bde); // One lane a beat
		do_write(6'h04, 16'hffff); // No lane written
		do_write(6'h08, 16'(xs()));
		do_write(6'h0c, 16'(xs())); // Still buffered
		repeat (12 * KH) @(negedge clock);
		// Back-to-back reads with a write slipped among them
		for (int b = 0; b < 8; b++) begin
			do_read(6'(b * 4));
			if (b == 3) do_write(6'h28, 16'h0000);
		end
		repeat (16 * KH) @(negedge clock);
		do_read(6'h28);
		for (int n = 0; n < 400 * KH && exp_q.size() != 0; n++) @(negedge clock);
		if (exp_q.size() != 0) begin
			fails++;
			$display("ERROR %0t read beats missing", $time);
		end
		dll_en = 1'b0;
		repeat (8) @(negedge clock);
		cmp_bit(dll_active, 1'b0); // Loop off
		dll_en = 1'b1;
		repeat (8) @(negedge clock);
		cmp_bit(dll_active, 1'b1); // Loop back on
		cmp_bit(link.read_data_oe, 1'b0); // Idle bus released
		end_sim();
	end
endmodule // burst4_ddr_sram_interface_bench
`default_nettype wire
